/* File: shared/sppi_defines.svh */
`ifndef SPPI_DEFINES_SVH
`define SPPI_DEFINES_SVH

// Register indices; byte address is four times the index
`define SPPI_IDX_ADDR       8'h00
`define SPPI_IDX_CFG        8'h03
`define SPPI_IDX_MODE       8'h05
`define SPPI_IDX_OUT_CTL    8'h0d
`define SPPI_IDX_STATUS     8'h10

// Reset values and address strap base
`define SPPI_CFG_RST        1'b1
`define SPPI_MODE_RST       2'h0
`define SPPI_OUT_CTL_RST    8'h00
`define SPPI_ADDR_BASE      7'h30

// Field positions
`define SPPI_CFG_EDGE_BIT   0
`define SPPI_OUT_SEL_LSB    4
`define SPPI_ST_OSC_BIT     0
`define SPPI_ST_VIOL_BIT    1
`define SPPI_ST_OVF_BIT     2
`define SPPI_ST_PLL_BIT     3
`define SPPI_ST_LEVEL_LSB   4
`define SPPI_ST_LSYNC_BIT   8
`define SPPI_ST_FSYNC_BIT   9

// Strap decode
`define SPPI_MODE_OSC_MIN   3'h4

// Pixel and frame geometry
`define SPPI_SYNC_MIN_GAP   4'd10
`define SPPI_FRAME_UI       28
`define SPPI_FRAME_W        28
`define SPPI_ACC_W          56
`define SPPI_UNIT_10B       6'd12
`define SPPI_UNIT_12B       6'd14
`define SPPI_EMIT_LOW       6'd14
`define SPPI_EMIT_HIGH      6'd21
`define SPPI_EMIT_10B       6'd24
`define SPPI_FIFO_DEPTH     8
`define SPPI_FIFO_LW        4

// Timing
`define SPPI_ACLK_MHZ       40
`define SPPI_OSC_HALF_NS    25
`define SPPI_OSC_HALF_CYC   ((`SPPI_OSC_HALF_NS * `SPPI_ACLK_MHZ) / 1000)

`endif

/* File: shared/sppi_pkg.sv */
`include "sppi_defines.svh"

package sppi_pkg;

  typedef enum logic [1:0] {
    mode_low_rate_12b  = 2'b00,
    mode_high_rate_12b = 2'b01,
    mode_ten_bit       = 2'b10
  } sppi_mode_type;

  typedef enum logic {
    clk_src_pixel = 1'b0,
    clk_src_osc   = 1'b1
  } sppi_clk_src_type;

  typedef logic [`SPPI_FRAME_W-1:0] sppi_frame_type;

endpackage

/* File: shared/sppi_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface sppi_fifo_if #(
  parameter int WIDTH = 28,
  parameter int LW    = 4
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic [LW-1:0]    level;

  modport fifo (
    input  wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, level
  );

  modport user (
    output wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data, level
  );
endinterface

`default_nettype wire

/* File: hw/sppi_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module sppi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sppi_sync

`default_nettype wire

/* File: hw/sppi_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module sppi_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic flush,
  // Both stream sides
  sppi_fifo_if.fifo port_if
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [LW-1:0]    count;
  logic             push;
  logic             load;

  assign port_if.wr_ready = (count != LW'(DEPTH));
  assign push = port_if.wr_valid && port_if.wr_ready;
  // Output register refills as soon as it empties or is taken
  assign load = (count != '0) && (!port_if.rd_valid || port_if.rd_ready);
  assign port_if.level = LW'(count + {{(LW-1){1'b0}}, port_if.rd_valid});

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= port_if.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (load) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= LW'(count + {{(LW-1){1'b0}}, push} - {{(LW-1){1'b0}}, load});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      port_if.rd_valid <= 1'b0;
      port_if.rd_data  <= '0;
    end else if (load) begin
      port_if.rd_valid <= 1'b1;
      port_if.rd_data  <= mem[rd_ptr];
    end else if (port_if.rd_ready) begin
      port_if.rd_valid <= 1'b0;
    end
  end
endmodule // sppi_fifo

`default_nettype wire

/* File: hw/sppi_pixel_in.sv */
// Overview of operation
// - Ten-bit mode uses only ten low inputs
// - Twelve-bit modes capture all twelve data inputs
// - Twelve-bit modes pass syncs raw, unrestricted
// - Sample on edge chosen by edge select
// - Outputs 0,1 follow remote or local bit
// - Output 2 remote, local, or oscillator clock
// - Pin 3 remote, local, or oscillator clock input
// - Mode strap picks pixel or oscillator timing
// - Address strap sets control bus address
// - Power-down low stops block and PLL
// - Power-down returns every register to default
// - Frames of 28 UI at mode's rate
`include "sppi_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sppi_pixel_in (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Sensor parallel bus
  input  wire logic                  pixel_clock,
  input  wire logic [11:0]           pixel_data,
  input  wire logic                  line_sync,
  input  wire logic                  frame_sync,
  // Straps and power
  input  wire logic [2:0]            mode_strap,
  input  wire logic [2:0]            address_strap,
  input  wire logic                  power_down_n,
  output logic                       pll_enable,
  output logic [6:0]                 target_address,
  // General-purpose pins
  input  wire logic [3:0]            remote_gpio,
  input  wire logic                  oscillator_clock_in,
  output logic [3:0]                 general_out_pin,
  output logic [3:0]                 general_out_oe,
  // Serial frame stream
  output sppi_pkg::sppi_frame_type   frame_data,
  output logic                       frame_valid,
  input  wire logic                  frame_ready
);
  import sppi_pkg::*;

  localparam int SW = 23;
  localparam logic [7:0] OSC_HALF = 8'(`SPPI_OSC_HALF_CYC);

  logic [SW-1:0]    pin_raw;
  logic [SW-1:0]    pin_q;
  logic             pclk_q;
  logic [11:0]      pdata_q;
  logic             lsync_q;
  logic             fsync_q;
  logic             oin_q;
  logic             pdn_q;
  logic [2:0]       mstrap_q;
  logic [2:0]       astrap_q;
  logic             pd_active;
  logic             reg_rst;
  logic             strap_done;
  sppi_clk_src_type clk_src;
  logic             edge_sel;
  sppi_mode_type    pay_mode;
  logic [7:0]       out_ctl;
  logic             is_ten;
  logic             strobe_lvl;
  logic             strobe_prev;
  logic             cap;
  logic             pix_stb;
  logic [11:0]      cap_pix;
  logic [1:0]       sync_cap;
  logic [3:0]       gap_cnt [2];
  logic             viol_set;
  logic             viol_flag;
  logic             ovf_flag;
  logic [5:0]       unit_w;
  logic [5:0]       ew;
  logic [55:0]      unit_bits;
  logic [55:0]      acc;
  logic [5:0]       acc_cnt;
  logic [55:0]      next_acc;
  logic [5:0]       next_cnt;
  logic             push_ok;
  logic [27:0]      emit_mask;
  logic [7:0]       osc_div;
  logic             osc_clock_out;
  logic [3:0]       out_sel;
  logic [31:0]      aw_addr;
  logic             aw_hold;
  logic [31:0]      w_data;
  logic             w_strb0;
  logic             w_hold;
  logic             wr_go;
  logic [7:0]       w_idx;
  logic [7:0]       r_idx;
  logic [31:0]      rd_word;
  logic             r_hit;

  sppi_fifo_if #(.WIDTH(`SPPI_FRAME_W), .LW(`SPPI_FIFO_LW)) fifo_if ();

  function automatic logic idx_mapped(input logic [31:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[31:10] == '0) && (a[1:0] == 2'b00) &&
           (i == `SPPI_IDX_ADDR || i == `SPPI_IDX_CFG || i == `SPPI_IDX_MODE ||
            i == `SPPI_IDX_OUT_CTL || i == `SPPI_IDX_STATUS);
  endfunction

  // Every pin but remote_gpio enters through two flops
  assign pin_raw = {pixel_clock, pixel_data, line_sync, frame_sync, oscillator_clock_in,
                    power_down_n, mode_strap, address_strap};

  sppi_sync #(.WIDTH(SW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_raw),
    .q       (pin_q)
  );

  assign {pclk_q, pdata_q, lsync_q, fsync_q, oin_q, pdn_q, mstrap_q, astrap_q} = pin_q;

  assign pd_active = !pdn_q;
  assign reg_rst   = !aresetn || pd_active;
  assign is_ten    = (pay_mode == mode_ten_bit);

  always_ff @(posedge aclk) begin
    pll_enable <= aresetn && !pd_active;
  end

  // Straps caught once after each power-up
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      strap_done     <= 1'b0;
      target_address <= '0;
      clk_src        <= clk_src_pixel;
    end else if (!strap_done) begin
      strap_done     <= 1'b1;
      target_address <= 7'(`SPPI_ADDR_BASE + {4'h0, astrap_q});
      clk_src        <= (mstrap_q >= `SPPI_MODE_OSC_MIN) ? clk_src_osc : clk_src_pixel;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      edge_sel <= `SPPI_CFG_RST;
      pay_mode <= sppi_mode_type'(`SPPI_MODE_RST);
      out_ctl  <= `SPPI_OUT_CTL_RST;
    end else if (wr_go && w_strb0) begin
      case (w_idx)
        `SPPI_IDX_CFG: begin
          edge_sel <= w_data[`SPPI_CFG_EDGE_BIT];
        end
        `SPPI_IDX_MODE: begin
          if (w_data[1:0] != 2'b11) begin
            pay_mode <= sppi_mode_type'(w_data[1:0]);
          end
        end
        `SPPI_IDX_OUT_CTL: begin
          out_ctl <= w_data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Strobe edge; in oscillator mode the sensor runs off our clock out
  assign strobe_lvl = (clk_src == clk_src_osc) ? oin_q : pclk_q;
  assign cap = edge_sel ? (strobe_lvl && !strobe_prev)
                        : (!strobe_lvl && strobe_prev);

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      strobe_prev <= strobe_lvl; // Tracks pin so wake-up shows no edge
      pix_stb     <= 1'b0;
      cap_pix     <= '0;
      sync_cap    <= '0;
    end else begin
      strobe_prev <= strobe_lvl;
      pix_stb     <= cap;
      if (cap) begin
        cap_pix  <= is_ten ? {2'b00, pdata_q[9:0]} : pdata_q;
        sync_cap <= {fsync_q, lsync_q};
      end
    end
  end

  // Sync toggle spacing checked only in ten-bit mode
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      gap_cnt[0] <= 4'hf;
      gap_cnt[1] <= 4'hf;
      viol_set   <= 1'b0;
    end else begin
      viol_set <= 1'b0;
      if (cap) begin
        for (int i = 0; i < 2; i++) begin
          if ((i == 0 ? lsync_q : fsync_q) != sync_cap[i]) begin
            gap_cnt[i] <= 4'h0;
            if (is_ten && gap_cnt[i] < 4'(`SPPI_SYNC_MIN_GAP - 4'd1)) begin
              viol_set <= 1'b1;
            end
          end else if (gap_cnt[i] != 4'hf) begin
            gap_cnt[i] <= 4'(gap_cnt[i] + 4'd1);
          end
        end
      end
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      viol_flag <= 1'b0;
      ovf_flag  <= 1'b0;
    end else begin
      if (viol_set) begin
        viol_flag <= 1'b1;
      end else if (wr_go && w_strb0 && w_idx == `SPPI_IDX_STATUS
                   && w_data[`SPPI_ST_VIOL_BIT]) begin
        viol_flag <= 1'b0;
      end
      if (pix_stb && !push_ok) begin
        ovf_flag <= 1'b1;
      end else if (wr_go && w_strb0 && w_idx == `SPPI_IDX_STATUS
                   && w_data[`SPPI_ST_OVF_BIT]) begin
        ovf_flag <= 1'b0;
      end
    end
  end

  // Packing: each unit carries both syncs raw beside the pixel
  assign unit_w    = is_ten ? `SPPI_UNIT_10B : `SPPI_UNIT_12B;
  assign unit_bits = is_ten ? {44'h0, sync_cap, cap_pix[9:0]}
                            : {42'h0, sync_cap, cap_pix};

  // Bits per 28 UI frame set the frame rate against the pixel rate
  always_comb begin
    case (pay_mode)
      mode_low_rate_12b:  ew = `SPPI_EMIT_LOW;
      mode_high_rate_12b: ew = `SPPI_EMIT_HIGH;
      mode_ten_bit:       ew = `SPPI_EMIT_10B;
      default:            ew = `SPPI_EMIT_LOW;
    endcase
  end

  assign emit_mask        = 28'((28'h1 << ew) - 28'h1);
  assign fifo_if.wr_valid = (acc_cnt >= ew);
  assign fifo_if.wr_data  = acc[27:0] & emit_mask;

  // A full FIFO stalls emission; pixels then pile up and overflow
  always_comb begin
    next_acc = acc;
    next_cnt = acc_cnt;
    if (fifo_if.wr_valid && fifo_if.wr_ready) begin
      next_acc = acc >> ew;
      next_cnt = 6'(acc_cnt - ew);
    end
    push_ok = pix_stb && (({1'b0, next_cnt} + {1'b0, unit_w}) <= 7'(`SPPI_ACC_W));
    if (push_ok) begin
      next_acc = next_acc | (unit_bits << next_cnt);
      next_cnt = 6'(next_cnt + unit_w);
    end
  end

  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      acc     <= '0;
      acc_cnt <= '0;
    end else begin
      acc     <= next_acc;
      acc_cnt <= next_cnt;
    end
  end

  sppi_fifo #(.WIDTH(`SPPI_FRAME_W), .DEPTH(`SPPI_FIFO_DEPTH), .LW(`SPPI_FIFO_LW)) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (pd_active),
    .port_if (fifo_if.fifo)
  );

  assign fifo_if.rd_ready = frame_ready;
  assign frame_data       = fifo_if.rd_data;
  assign frame_valid      = fifo_if.rd_valid;

  // Oscillator clock out, a divided copy of aclk
  always_ff @(posedge aclk) begin
    if (reg_rst || clk_src != clk_src_osc) begin
      osc_div       <= '0;
      osc_clock_out <= 1'b0;
    end else if (osc_div == OSC_HALF - 8'd1) begin
      osc_div       <= '0;
      osc_clock_out <= !osc_clock_out;
    end else begin
      osc_div <= 8'(osc_div + 8'd1);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      out_sel[i] = out_ctl[`SPPI_OUT_SEL_LSB + i] ? out_ctl[i] : remote_gpio[i];
    end
  end

  // Pins float during power-down
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      general_out_pin <= '0;
      general_out_oe  <= '0;
    end else begin
      general_out_pin[1:0] <= out_sel[1:0];
      general_out_pin[2]   <= (clk_src == clk_src_osc) ? osc_clock_out : out_sel[2];
      general_out_pin[3]   <= out_sel[3];
      general_out_oe       <= {clk_src != clk_src_osc, 3'b111};
    end
  end

  // AXI write path; address and data in either order
  assign w_idx = aw_addr[9:2];
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb0       <= 1'b0;
    end else begin
      if (!aw_hold && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_hold && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_hold       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb0      <= s_axi_wstrb[0];
        w_hold       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_mapped(aw_addr) ? 2'b00 : 2'b10;
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read path
  assign r_idx = s_axi_araddr[9:2];
  assign r_hit = idx_mapped(s_axi_araddr);

  always_comb begin
    rd_word = '0;
    case (r_idx)
      `SPPI_IDX_ADDR:    rd_word[7:1] = target_address;
      `SPPI_IDX_CFG:     rd_word[`SPPI_CFG_EDGE_BIT] = edge_sel;
      `SPPI_IDX_MODE:    rd_word[1:0] = pay_mode;
      `SPPI_IDX_OUT_CTL: rd_word[7:0] = out_ctl;
      `SPPI_IDX_STATUS: begin
        rd_word[`SPPI_ST_OSC_BIT]  = (clk_src == clk_src_osc);
        rd_word[`SPPI_ST_VIOL_BIT] = viol_flag;
        rd_word[`SPPI_ST_OVF_BIT]  = ovf_flag;
        rd_word[`SPPI_ST_PLL_BIT]  = pll_enable;
        rd_word[`SPPI_ST_LEVEL_LSB +: `SPPI_FIFO_LW] = fifo_if.level;
        rd_word[`SPPI_ST_LSYNC_BIT] = sync_cap[0];
        rd_word[`SPPI_ST_FSYNC_BIT] = sync_cap[1];
      end
      default:           rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= r_hit ? rd_word : 32'h0;
      s_axi_rresp   <= r_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule // sppi_pixel_in

`default_nettype wire

/* File: testbench/sppi_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module sppi_checker (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Power, straps and pins
  input wire logic                     power_down_n,
  input wire logic                     pll_enable,
  input wire logic [6:0]               target_address,
  input wire logic [2:0]               mode_strap,
  input wire logic [2:0]               address_strap,
  input wire logic [3:0]               general_out_pin,
  input wire logic [3:0]               general_out_oe,
  // Frame stream
  input wire sppi_pkg::sppi_frame_type frame_data,
  input wire logic                     frame_valid,
  input wire logic                     frame_ready
);
  import sppi_pkg::*;
  logic [3:0] pd_hist;
  logic       run;
  always_ff @(posedge aclk) begin
    pd_hist <= {pd_hist[2:0], power_down_n};
  end
  // Running only once the pin has been high long enough to pass the synchroniser
  assign run = (&pd_hist) && power_down_n && pll_enable;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_pll_stop: assert property ((!power_down_n)[*4] |-> !pll_enable)
    else $error("pll on in power-down");
  chk_pins_off: assert property ((!power_down_n)[*4] |-> general_out_oe == 4'h0 && general_out_pin == 4'h0)
    else $error("pins driven in power-down");
  chk_addr_clear: assert property ((!power_down_n)[*4] |-> target_address == 7'h00 && !frame_valid)
    else $error("state kept in power-down");
  chk_pll_start: assert property ($rose(pll_enable) |-> $past(power_down_n, 2))
    else $error("pll started without enable");
  chk_addr_strap: assert property (run |-> target_address == 7'h30 + {4'h0, address_strap})
    else $error("target address not from strap");
  chk_oe_mode: assert property (run && $past(run) |->
    general_out_oe == ((mode_strap >= 3'h4) ? 4'h7 : 4'hf))
    else $error("pin enables wrong for timing mode");
  chk_clk_out: assert property (run && $past(run, 2) && mode_strap >= 3'h4 |->
    general_out_pin[2] != $past(general_out_pin[2]))
    else $error("clock out not toggling");
  chk_frame_hold: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("frame dropped while stalled");

  cover property (frame_valid && frame_ready);
  cover property (frame_valid && !frame_ready);
  cover property (run && mode_strap >= 3'h4);
endmodule // sppi_checker

bind sppi_pixel_in sppi_checker u_checker (
  .aclk, .aresetn, .power_down_n, .pll_enable, .target_address, .mode_strap,
  .address_strap, .general_out_pin, .general_out_oe, .frame_data, .frame_valid, .frame_ready
);

`default_nettype wire

/* File: testbench/sppi_sensor_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sppi_sensor_model (
  // Sensor pins
  output logic        pixel_clock,
  output logic        oscillator_clock_in,
  output logic [11:0] pixel_data,
  output logic        line_sync,
  output logic        frame_sync
);
  initial begin
    pixel_clock = 1'b0;
    {frame_sync, line_sync, pixel_data} = 14'h0;
  end
  // Same wave on pin 3 serves oscillator mode
  assign oscillator_clock_in = pixel_clock;
  // One 100 ns pulse per unit, slow so aclk oversamples it; clock idles between units
  task automatic send(input logic [11:0] pix, input logic ls, input logic fs, input logic rise);
    pixel_clock = ~rise;
    {frame_sync, line_sync, pixel_data} = {fs, ls, pix};
    #100 pixel_clock = rise;
    #100 pixel_clock = ~rise;
    // Hold has run out: inverse shown so a wrong-edge capture is seen
    {frame_sync, line_sync, pixel_data} = ~{fs, ls, pix};
    #100;
  endtask
endmodule // sppi_sensor_model

`default_nettype wire

/* File: testbench/sppi_pixel_in_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module sppi_pixel_in_bench;
  import sppi_pkg::*;
  logic aclk, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, remote_gpio = 4'h0, general_out_pin, general_out_oe;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, frame_ready = 1'b1, power_down_n = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] mode_strap = 3'h1, address_strap = 3'h5;
  logic pixel_clock, line_sync, frame_sync, oscillator_clock_in, pll_enable, frame_valid;
  logic [11:0] pixel_data;
  logic [6:0] target_address;
  sppi_frame_type frame_data;
  logic [31:0] rdat;
  logic [41:0] hs;
  logic [27:0] got[$];
  int n_errors = 0, tests_run = 0, cyc = 0;

  sppi_pixel_in DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pixel_clock, .pixel_data, .line_sync, .frame_sync,
    .mode_strap, .address_strap, .power_down_n, .pll_enable, .target_address, .remote_gpio,
    .oscillator_clock_in, .general_out_pin, .general_out_oe, .frame_data, .frame_valid,
    .frame_ready
  );
  sppi_sensor_model u_sensor (
    .pixel_clock, .oscillator_clock_in, .pixel_data, .line_sync, .frame_sync
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("errors %0d of %0d comparisons", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Ceiling is more than ten times the expected run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      end_sim();
    end
  end

  always @(posedge aclk) begin
    if (frame_valid === 1'b1 && frame_ready === 1'b1) got.push_back(frame_data);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (!aw && !w && s_axi_bvalid === 1'b1) break;
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    resp = s_axi_bresp;
    check({31'h0, s_axi_bvalid}, 32'h1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    logic ar;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar = 1'b1;
    repeat (50) begin
      @(posedge aclk);
      if (!ar && s_axi_rvalid === 1'b1) break;
      if (ar && s_axi_arready === 1'b1) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    rdat = s_axi_rdata;
    check({31'h0, s_axi_rvalid}, 32'h1);
    s_axi_rready <= 1'b0;
    check(rdat & m, e);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic fchk(input logic [27:0] e);
    repeat (60) if (got.size() == 0) @(posedge aclk);
    check({4'h0, (got.size() != 0) ? got.pop_front() : 28'hxxxxxxx}, {4'h0, e});
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(32'h00, 32'hff, 32'h6a, 2'b00);
    rchk(32'h0c, 32'h1, 32'h1, 2'b00);
    rchk(32'h14, 32'h3, 32'h0, 2'b00);
    rchk(32'h34, 32'hff, 32'h0, 2'b00);
    rchk(32'h40, 32'h3ff, 32'h8, 2'b00);
    rchk(32'h08, 32'hffffffff, 32'h0, 2'b10);
    wr(32'h08, 32'h1);
    check(resp, 2'b10);
    remote_gpio <= 4'ha;
    repeat (3) @(posedge aclk);
    check(general_out_pin, 4'ha);
    wr(32'h34, 32'h35);
    repeat (3) @(posedge aclk);
    check(general_out_pin, 4'h9);
    wr(32'h34, 32'hfc);
    repeat (3) @(posedge aclk);
    check(general_out_pin, 4'hc);
    // Line sync toggles on every unit, frame sync on the last two, allowed in twelve-bit modes
    u_sensor.send(12'habc, 1'b1, 1'b0, 1'b1);
    fchk(28'h0001abc);
    u_sensor.send(12'h123, 1'b0, 1'b1, 1'b1);
    fchk(28'h0002123);
    u_sensor.send(12'h456, 1'b1, 1'b0, 1'b1);
    fchk(28'h0001456);
    rchk(32'h40, 32'h302, 32'h100, 2'b00);
    wr(32'h0c, 32'h0);
    u_sensor.send(12'h5a5, 1'b0, 1'b0, 1'b0);
    fchk(28'h00005a5);
    wr(32'h14, 32'h1);
    u_sensor.send(12'h111, 1'b0, 1'b0, 1'b0);
    u_sensor.send(12'h222, 1'b1, 1'b0, 1'b0);
    u_sensor.send(12'h333, 1'b1, 1'b1, 1'b0);
    hs = {14'h3333, 14'h1222, 14'h0111};
    fchk({7'h0, hs[20:0]});
    fchk({7'h0, hs[41:21]});
    // Back-to-back line toggles break the ten-bit spacing on purpose
    wr(32'h14, 32'h2);
    u_sensor.send(12'hc55, 1'b0, 1'b0, 1'b0);
    u_sensor.send(12'hfaa, 1'b1, 1'b0, 1'b0);
    fchk(28'h07aa055);
    rchk(32'h40, 32'h2, 32'h2, 2'b00);
    wr(32'h40, 32'h2);
    rchk(32'h40, 32'h2, 32'h0, 2'b00);
    wr(32'h14, 32'h0);
    frame_ready <= 1'b0;
    for (int i = 0; i < 14; i++) u_sensor.send(i[11:0], 1'b0, 1'b0, 1'b0);
    rchk(32'h40, 32'hf4, 32'h94, 2'b00);
    frame_ready <= 1'b1;
    for (int i = 0; i < 13; i++) fchk({16'h0, i[11:0]});
    rchk(32'h40, 32'hf0, 32'h0, 2'b00);
    wr(32'h40, 32'h4);
    rchk(32'h40, 32'h4, 32'h0, 2'b00);
    wr(32'h14, 32'h1);
    wr(32'h34, 32'hff);
    power_down_n <= 1'b0;
    address_strap <= 3'h2;
    mode_strap <= 3'h6;
    repeat (8) @(posedge aclk);
    check(pll_enable, 1'b0);
    power_down_n <= 1'b1;
    repeat (6) @(posedge aclk);
    rchk(32'h00, 32'hff, 32'h64, 2'b00);
    rchk(32'h0c, 32'h1, 32'h1, 2'b00);
    rchk(32'h14, 32'h3, 32'h0, 2'b00);
    rchk(32'h34, 32'hff, 32'h0, 2'b00);
    rchk(32'h40, 32'hf, 32'h9, 2'b00);
    u_sensor.send(12'h777, 1'b0, 1'b0, 1'b1);
    fchk(28'h0000777);
    end_sim();
  end
endmodule // sppi_pixel_in_bench

`default_nettype wire
